// *** rtl/sbcw_pkg.sv ***
// package for the serial bit counter, status and wait control block
// assumes a register-file port addressed by the processor's indirect_read_instr/indirect_write_instr path
package sbcw_pkg;
   // register-file addresses
   localparam logic [6:0] SBCW_ADDR_STATUS = 7'h28; // status flags, read only
   localparam logic [6:0] SBCW_ADDR_WAIT = 7'h29; // wait control
   // status bit positions
   localparam int SBCW_ST_BUSY = 0;
   localparam int SBCW_ST_START = 1;
   localparam int SBCW_ST_NINE = 2;
   localparam int SBCW_ST_EIGHT = 3;
   // wait register bit positions
   localparam int SBCW_WT_LO = 0;
   localparam int SBCW_WT_HI = 1;
   localparam int SBCW_WT_NOWAIT = 2;
   localparam int SBCW_WT_ACK = 3;
   // reset values and counts
   localparam logic [3:0] SBCW_WAIT_RST = 4'h0;
   localparam logic [3:0] SBCW_CNT_ZERO = 4'h0;
   localparam logic [3:0] SBCW_CNT_ONE = 4'h1;
   localparam logic [3:0] SBCW_CNT_EIGHT = 4'h8;
   localparam logic [3:0] SBCW_CNT_NINE = 4'h9;
   // wait timing selections
   localparam logic [1:0] SBCW_WSEL_NONE = 2'h0;
   localparam logic [1:0] SBCW_WSEL_DATA = 2'h1;
   localparam logic [1:0] SBCW_WSEL_ACK = 2'h2;
   localparam logic [1:0] SBCW_WSEL_ADDR = 2'h3;
   // link-side event kinds are carried as toggles
   typedef struct packed {
      logic [1:0] clk_sync_0;
      logic [1:0] clk_sync_1;
      logic [1:0] dat_sync;
      logic clk_prev;
      logic dat_prev;
      logic [1:0] sel_sync;
      logic [1:0] proto_sync;
      logic start_tgl;
      logic stop_tgl;
   } sbcw_link_t;
   typedef struct packed {
      logic [1:0] start_s;
      logic start_d;
      logic [1:0] stop_s;
      logic stop_d;
      logic [1:0] ck0_s;
      logic [1:0] ck1_s;
      logic ck_prev;
      logic proto_prev;
      logic [3:0] count;
      logic eight;
      logic nine;
      logic start_seen;
      logic busy;
      logic [3:0] wreg;
      logic waiting;
      logic addr_armed;
      logic [3:0] rdata;
   } sbcw_sys_t;
endpackage

// *** rtl/sbcw_top.sv ***
// bit counter, status flags and wait control of the serial interface
// assumes register-file strobes from the processor on sys_clk_i, and raw
// bus pins on channel 0 (clock and data) plus channel 1 clock
//
// What this block does
// [RULE_01] count each rising shift-clock edge from zero
// [RULE_02] after nine, next edge loads one
// [RULE_03] bus mode: clear on reset, stop, start, mode
// [RULE_04] serial mode: clear on reset, stop, wait write, mode
// [RULE_05] four-bit read-only status register at 28h
// [RULE_06] busy set by start, cleared by stop
// [RULE_07] serial mode forces busy to zero
// [RULE_08] start flag set by start, cleared at nine
// [RULE_09] nine flag set at nine, cleared zero/one
// [RULE_10] eight flag set at eight, cleared zero/one
// [RULE_11] software reads shift data while eight flag set
// [RULE_12] master reads ack between nine flag events
// [RULE_13] waiting blocks shift clock to counter, register
// [RULE_14] wait register: ack, not-waiting, two-bit timing
// [RULE_15] wait register cleared on reset and stop
// [RULE_16] wait register reached only by indirect_read_instr/indirect_write_instr
// [RULE_17] select 01 bus: wait falling edge at eight
// [RULE_18] select 10 bus: wait falling edge at nine
// [RULE_19] select 11 bus: first eight after start
// [RULE_20] serial mode: wait high at eight or nine
// [RULE_21] protocol select zero serial, one bus
// [RULE_22] channel select picks counter clock source
// [RULE_23] writing one to not-waiting releases wait
// [RULE_24] synchronise clock and start/stop before use
// [RULE_25] status reads harmless, status writes ignored
`timescale 1ns/1ps
module sbcw_top
   import sbcw_pkg::*;
(
   // system side
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic clock_stop_i,
   // link clock domain
   input wire logic link_clk_i,
   input wire logic link_rst_i,
   // mode bits
   input wire logic protocol_select_i,
   input wire logic channel_select_i,
   // register file port
   input wire logic [6:0] rf_addr_i,
   input wire logic rf_rd_i,
   input wire logic rf_wr_i,
   input wire logic [3:0] rf_wdata_i,
   output logic [3:0] rf_rdata_o,
   // pins
   input wire logic ch0_clock_pin_i,
   input wire logic ch1_clock_pin_i,
   input wire logic ch0_data_pin_i,
   // to shift register and pin logic
   output logic shift_enable_o,
   output logic waiting_o,
   output logic ack_bit_o,
   output logic [3:0] bit_count_o
);
   import sbcw_pkg::*;

   sbcw_link_t lk, next_lk;
   sbcw_sys_t st, next_st;

   // start/stop detection on the link clock, after two-stage pin sync
   always_comb begin
      logic ck, dt;
      ck = 1'b0;
      dt = 1'b0;
      next_lk = lk;
      next_lk.clk_sync_0 = {lk.clk_sync_0[0], ch0_clock_pin_i};
      next_lk.clk_sync_1 = {lk.clk_sync_1[0], ch1_clock_pin_i};
      next_lk.dat_sync = {lk.dat_sync[0], ch0_data_pin_i};
      next_lk.sel_sync = {lk.sel_sync[0], channel_select_i};
      next_lk.proto_sync = {lk.proto_sync[0], protocol_select_i};
      ck = lk.sel_sync[1] ? lk.clk_sync_1[1] : lk.clk_sync_0[1];
      dt = lk.dat_sync[1];
      next_lk.clk_prev = ck;
      next_lk.dat_prev = dt;
      // data falls while clock high: start; rises: stop
      if (lk.proto_sync[1] && ck && lk.clk_prev) begin
         if (lk.dat_prev && !dt) begin
            next_lk.start_tgl = ~lk.start_tgl; // RULE_24
         end
         if (!lk.dat_prev && dt) begin
            next_lk.stop_tgl = ~lk.stop_tgl; // RULE_24
         end
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         lk <= '0;
      end else begin
         lk <= next_lk;
      end
   end

   // counter, status flags and wait state on the system clock
   always_comb begin
      logic start_ev, stop_ev, ck, rise, fall, mode_chg, clr;
      logic wait_wr, stat_rd, wait_rd, enter;
      logic [3:0] cnt;
      start_ev = 1'b0;
      stop_ev = 1'b0;
      ck = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      mode_chg = 1'b0;
      clr = 1'b0;
      wait_wr = 1'b0;
      stat_rd = 1'b0;
      wait_rd = 1'b0;
      enter = 1'b0;
      cnt = st.count;
      next_st = st;
      // toggle crossings and clock pin sync
      next_st.start_s = {st.start_s[0], lk.start_tgl};
      next_st.start_d = st.start_s[1];
      next_st.stop_s = {st.stop_s[0], lk.stop_tgl};
      next_st.stop_d = st.stop_s[1];
      next_st.ck0_s = {st.ck0_s[0], ch0_clock_pin_i};
      next_st.ck1_s = {st.ck1_s[0], ch1_clock_pin_i};
      start_ev = st.start_s[1] ^ st.start_d; // RULE_24
      stop_ev = st.stop_s[1] ^ st.stop_d;
      ck = channel_select_i ? st.ck1_s[1] : st.ck0_s[1]; // RULE_22
      next_st.ck_prev = ck;
      rise = ck && !st.ck_prev && !st.waiting; // RULE_13
      fall = !ck && st.ck_prev && !st.waiting;
      next_st.proto_prev = protocol_select_i;
      mode_chg = protocol_select_i != st.proto_prev; // RULE_21
      // register file decode; indirect_read_instr/indirect_write_instr only path to wait register
      wait_wr = rf_wr_i && rf_addr_i == SBCW_ADDR_WAIT; // RULE_16
      wait_rd = rf_rd_i && rf_addr_i == SBCW_ADDR_WAIT;
      stat_rd = rf_rd_i && rf_addr_i == SBCW_ADDR_STATUS; // RULE_05 RULE_25
      // counter clears
      clr = mode_chg // RULE_03 RULE_04
         || (protocol_select_i && start_ev) // RULE_03
         || (!protocol_select_i && wait_wr); // RULE_04
      if (clr) begin
         cnt = SBCW_CNT_ZERO;
      end else if (rise) begin
         cnt = (st.count == SBCW_CNT_NINE) ? SBCW_CNT_ONE // RULE_02
            : 4'(st.count + SBCW_CNT_ONE); // RULE_01
      end
      next_st.count = cnt;
      // eight and nine flags follow the counter in either mode
      if (cnt != st.count) begin
         if (cnt == SBCW_CNT_EIGHT) next_st.eight = 1'b1; // RULE_10
         if (cnt == SBCW_CNT_NINE) next_st.nine = 1'b1; // RULE_09
         if (cnt == SBCW_CNT_ZERO || cnt == SBCW_CNT_ONE) begin
            next_st.eight = 1'b0; // RULE_10
            next_st.nine = 1'b0; // RULE_09
         end
      end
      // bus busy and start-seen flags
      if (!protocol_select_i) begin
         next_st.busy = 1'b0; // RULE_07
         next_st.start_seen = 1'b0;
      end else begin
         if (stop_ev) next_st.busy = 1'b0; // RULE_06
         if (start_ev) next_st.busy = 1'b1; // RULE_06
         if (cnt == SBCW_CNT_NINE && cnt != st.count) next_st.start_seen = 1'b0; // RULE_08
         if (start_ev) next_st.start_seen = 1'b1; // RULE_08
      end
      // address wait armed by each start
      if (start_ev) next_st.addr_armed = 1'b1;
      // wait entry by timing select
      unique case (st.wreg[SBCW_WT_HI:SBCW_WT_LO])
         SBCW_WSEL_NONE: enter = 1'b0; // RULE_17
         SBCW_WSEL_DATA: enter = protocol_select_i ? (fall && st.count == SBCW_CNT_EIGHT)
            : (rise && cnt == SBCW_CNT_EIGHT); // RULE_17 RULE_20
         SBCW_WSEL_ACK: enter = protocol_select_i ? (fall && st.count == SBCW_CNT_NINE)
            : (rise && cnt == SBCW_CNT_NINE); // RULE_18 RULE_20
         SBCW_WSEL_ADDR: enter = protocol_select_i && fall
            && st.count == SBCW_CNT_EIGHT && st.addr_armed; // RULE_19
      endcase
      if (enter) begin
         next_st.waiting = 1'b1; // RULE_13
         next_st.wreg[SBCW_WT_NOWAIT] = 1'b0;
         if (st.wreg[SBCW_WT_HI:SBCW_WT_LO] == SBCW_WSEL_ADDR) next_st.addr_armed = 1'b0;
      end
      // indirect_write_instr into the wait register; not-waiting bit forces or releases
      if (wait_wr) begin
         next_st.wreg = rf_wdata_i; // RULE_14
         next_st.waiting = !rf_wdata_i[SBCW_WT_NOWAIT]; // RULE_23
      end
      // read data: status reads only sample
      if (stat_rd) begin
         next_st.rdata = {st.eight, st.nine, st.start_seen, st.busy}; // RULE_05
      end else if (wait_rd) begin
         next_st.rdata = st.wreg;
      end else begin
         next_st.rdata = 4'h0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || clock_stop_i) begin
         st <= '0; // RULE_15 RULE_03 RULE_04
         st.wreg <= SBCW_WAIT_RST; // RULE_15
         // clock syncs rest at the idle-high pin level, so no false rise follows
         st.ck0_s <= 2'h3;
         st.ck1_s <= 2'h3;
         st.ck_prev <= 1'h1;
      end else begin
         st <= next_st;
      end
   end

   // outputs
   assign rf_rdata_o = st.rdata;
   assign shift_enable_o = !st.waiting; // RULE_13
   assign waiting_o = st.waiting;
   assign ack_bit_o = st.wreg[SBCW_WT_ACK];
   assign bit_count_o = st.count;
endmodule

// *** bench/sbcw_far.sv ***
// far-side bus device model: shift clock and data pins
// assumes bench calls its tasks; idle pins rest high on pull-ups
`timescale 1ns/1ps
module sbcw_far (
   // timing reference
   input wire logic sys_clk_i,
   // pins toward the block
   output logic ch0_clock_pin_o,
   output logic ch0_data_pin_o,
   output logic ch1_clock_pin_o
);
   int half = 8; // half period in system cycles, set slow or fast
   logic ck = 1'b1;
   logic use_ch1 = 1'b0;
   // the unused channel's clock stands still high
   assign ch0_clock_pin_o = use_ch1 | ck;
   assign ch1_clock_pin_o = !use_ch1 | ck;
   initial ch0_data_pin_o = 1'b1;
   task automatic hold();
      repeat (half) @(negedge sys_clk_i);
   endtask
   // start (lvl 0) or stop (lvl 1): data moves while clock is high
   task automatic cond(input logic lvl);
      ch0_data_pin_o = !lvl;
      hold();
      ch0_data_pin_o = lvl;
      hold();
   endtask
   // n clock pulses on one channel, each falling then rising
   task automatic pulse(input logic ch, input int n);
      use_ch1 = ch;
      repeat (n) begin
         ck = 1'b0;
         hold();
         ck = 1'b1;
         hold();
      end
   endtask
endmodule

// *** bench/sbcw_chk.sv ***
// port assertions for the bit counter, status and wait block
// assumes bind onto sbcw_top; all checks on the system clock
`timescale 1ns/1ps
module sbcw_chk
   import sbcw_pkg::*;
(
   // system side
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic clock_stop_i,
   input wire logic protocol_select_i,
   // register file port
   input wire logic [6:0] rf_addr_i,
   input wire logic rf_rd_i,
   input wire logic rf_wr_i,
   input wire logic [3:0] rf_wdata_i,
   input wire logic [3:0] rf_rdata_o,
   // toward shift logic
   input wire logic shift_enable_o,
   input wire logic waiting_o,
   input wire logic ack_bit_o,
   input wire logic [3:0] bit_count_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // write to the wait register that is not overridden by a clock stop
   sequence s_wwr;
      rf_wr_i && rf_addr_i == SBCW_ADDR_WAIT && !clock_stop_i;
   endsequence
   AST_CNT_STEP:
      assert property ($changed(bit_count_o) |-> bit_count_o == 4'h0 || bit_count_o <= 4'h9
         && bit_count_o == $past(bit_count_o) + 4'h1 || bit_count_o == 4'h1
         && $past(bit_count_o) == 4'h9) else $error("counter stepped wrongly");
   AST_WAIT_HOLD:
      assert property (waiting_o [*2] ##0 bit_count_o != 4'h0 |-> $stable(bit_count_o))
         else $error("counter moved while waiting");
   AST_EN_INV:
      assert property (shift_enable_o != waiting_o) else $error("enable not inverse of wait");
   AST_STATUS:
      assert property (rf_rd_i && rf_addr_i == SBCW_ADDR_STATUS |=> rf_rdata_o[3:2] ==
         {$past(bit_count_o) >= 4'h8, $past(bit_count_o) == 4'h9}) else $error("count flags");
   AST_RD_QUIET:
      assert property (!$past(rf_rd_i) |-> rf_rdata_o == 4'h0) else $error("read data not idle");
   AST_ACK_WR:
      assert property (s_wwr |=> ack_bit_o == $past(rf_wdata_i[SBCW_WT_ACK]))
         else $error("ack bit not written");
   AST_STOP_CLR:
      assert property (clock_stop_i |=> bit_count_o == 4'h0 && !ack_bit_o && !waiting_o)
         else $error("clock stop did not clear");
   AST_FORCE:
      assert property (s_wwr ##0 !rf_wdata_i[SBCW_WT_NOWAIT] |=> waiting_o)
         else $error("forced wait missing");
   AST_RELEASE:
      assert property (s_wwr ##0 rf_wdata_i[SBCW_WT_NOWAIT] |=> !waiting_o)
         else $error("wait not released");
   AST_SER_CLR:
      assert property (s_wwr ##0 !protocol_select_i |=> bit_count_o == 4'h0)
         else $error("wait write did not clear");
   AST_MODE_CLR:
      assert property ($changed(protocol_select_i) |-> ##[1:3] bit_count_o == 4'h0)
         else $error("mode change did not clear");
endmodule
bind sbcw_top sbcw_chk u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
   .clock_stop_i(clock_stop_i), .protocol_select_i(protocol_select_i), .rf_addr_i(rf_addr_i),
   .rf_rd_i(rf_rd_i), .rf_wr_i(rf_wr_i), .rf_wdata_i(rf_wdata_i), .rf_rdata_o(rf_rdata_o),
   .shift_enable_o(shift_enable_o), .waiting_o(waiting_o), .ack_bit_o(ack_bit_o),
   .bit_count_o(bit_count_o));

// *** bench/sbcw_top_tb_top.sv ***
// self-checking bench: register port driver plus far-side pin model
// assumes the checker binds itself onto sbcw_top
`timescale 1ns/1ps
module sbcw_top_tb_top;
   import sbcw_pkg::*;
   logic sys_clk_i = 1'b0, link_clk_i = 1'b0, rst = 1'b1, stop = 1'b0, k = 1'b0;
   logic proto = 1'b1, chan = 1'b0, rd = 1'b0, wr = 1'b0, rd_d = 1'b0;
   logic [6:0] addr = 7'h00;
   logic [3:0] wdata = 4'h0, rdata, cnt;
   logic en, wt, ack, ck0, ck1, dat;
   logic [9:0] exp_q[$];
   int err_total = 0, samples_checked = 0;
   sbcw_top DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(rst), .clock_stop_i(stop),
      .link_clk_i(link_clk_i), .link_rst_i(rst), .protocol_select_i(proto),
      .channel_select_i(chan), .rf_addr_i(addr), .rf_rd_i(rd), .rf_wr_i(wr),
      .rf_wdata_i(wdata), .rf_rdata_o(rdata), .ch0_clock_pin_i(ck0), .ch1_clock_pin_i(ck1),
      .ch0_data_pin_i(dat), .shift_enable_o(en), .waiting_o(wt), .ack_bit_o(ack),
      .bit_count_o(cnt));
   sbcw_far far (.sys_clk_i(sys_clk_i), .ch0_clock_pin_o(ck0), .ch0_data_pin_o(dat),
      .ch1_clock_pin_o(ck1));
   // clocks: system 10 ns, link 12 ns on its own phase
   initial forever #5 sys_clk_i = !sys_clk_i;
   initial begin
      #3.7;
      forever #6 link_clk_i = !link_clk_i;
   end
   task automatic check(input logic [9:0] seen, input logic [9:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_total++;
         $display("unexpected at %0t: seen %h want %h", $time, seen, want);
      end
   endtask
   // one-cycle register strobe, launched at the falling edge
   task automatic rf(input logic w, input logic [6:0] a, input logic [3:0] d);
      @(negedge sys_clk_i);
      addr = a;
      wr = w;
      rd = !w;
      wdata = d;
      @(negedge sys_clk_i);
      wr = 1'b0;
      rd = 1'b0;
   endtask
   // read and note the expected read data, count, wait and ack
   task automatic probe(input logic [6:0] a, input logic [3:0] d, input logic [3:0] c,
      input logic w);
      exp_q.push_back({d, c, w, k});
      rf(1'b0, a, 4'h0);
   endtask
   task automatic ps(input logic [3:0] c, input logic s, input logic b, input logic w);
      probe(SBCW_ADDR_STATUS, {c >= 4'h8, c == 4'h9, s, b}, c, w);
   endtask
   task automatic ww(input logic [1:0] s, input logic n);
      rf(1'b1, SBCW_ADDR_WAIT, {k, n, s});
   endtask
   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0 && exp_q.size() == 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // monitor: each read answer against the oldest note
   always @(posedge sys_clk_i) rd_d <= rd;
   always @(negedge sys_clk_i) if (rd_d) check({rdata, cnt, wt, ack}, exp_q.pop_front());
   // watchdog well beyond the expected run
   initial begin
      repeat (30000) @(posedge sys_clk_i);
      err_total++;
      summarize();
   end
   // main sequence
   initial begin
      void'($urandom(68196));
      far.half = 8 + $urandom % 8;
      repeat (16) @(negedge sys_clk_i);
      rst = 1'b0;
      ps(4'h0, 1'b0, 1'b0, 1'b0);
      k = 1'($urandom);
      ww(SBCW_WSEL_NONE, 1'b1);
      far.cond(1'b0);
      ps(4'h0, 1'b1, 1'b1, 1'b0);
      for (int i = 1; i <= 10; i++) begin
         far.pulse(1'b0, 1);
         ps(i == 10 ? 4'h1 : 4'(i), i < 9, 1'b1, 1'b0);
      end
      far.cond(1'b0);
      ps(4'h0, 1'b1, 1'b1, 1'b0);
      far.cond(1'b1);
      ps(4'h0, 1'b1, 1'b0, 1'b0);
      $display("test count done");
      ww(SBCW_WSEL_DATA, 1'b1);
      far.cond(1'b0);
      far.pulse(1'b0, 10);
      ps(4'h8, 1'b1, 1'b1, 1'b1);
      probe(SBCW_ADDR_WAIT, {k, 1'b0, SBCW_WSEL_DATA}, 4'h8, 1'b1);
      ww(SBCW_WSEL_ACK, 1'b1);
      far.pulse(1'b0, 2);
      ps(4'h9, 1'b0, 1'b1, 1'b1);
      ww(SBCW_WSEL_ADDR, 1'b1);
      far.cond(1'b0);
      far.pulse(1'b0, 10);
      ps(4'h8, 1'b1, 1'b1, 1'b1);
      ww(SBCW_WSEL_ADDR, 1'b1);
      far.pulse(1'b0, 10);
      ps(4'h9, 1'b0, 1'b1, 1'b0);
      $display("test bus wait done");
      proto = 1'b0;
      far.half = 8 + $urandom % 16;
      far.cond(1'b0);
      ps(4'h0, 1'b0, 1'b0, 1'b0);
      ww(SBCW_WSEL_DATA, 1'b1);
      far.pulse(1'b0, 9);
      ps(4'h8, 1'b0, 1'b0, 1'b1);
      ww(SBCW_WSEL_ACK, 1'b1);
      ps(4'h0, 1'b0, 1'b0, 1'b0);
      far.pulse(1'b0, 10);
      ps(4'h9, 1'b0, 1'b0, 1'b1);
      $display("test serial done");
      chan = 1'b1;
      ww(SBCW_WSEL_NONE, 1'b0);
      far.pulse(1'b1, 2);
      ps(4'h0, 1'b0, 1'b0, 1'b1);
      ww(SBCW_WSEL_NONE, 1'b1);
      far.pulse(1'b1, 3);
      far.pulse(1'b0, 2);
      ps(4'h3, 1'b0, 1'b0, 1'b0);
      rf(1'b1, SBCW_ADDR_STATUS, 4'hF);
      ps(4'h3, 1'b0, 1'b0, 1'b0);
      probe(7'h30, 4'h0, 4'h3, 1'b0);
      chan = 1'b0;
      proto = 1'b1;
      far.hold();
      ps(4'h0, 1'b0, 1'b0, 1'b0);
      $display("test channel done");
      far.pulse(1'b0, 2);
      stop = 1'b1;
      far.hold();
      stop = 1'b0;
      k = 1'b0;
      ps(4'h0, 1'b0, 1'b0, 1'b0);
      probe(SBCW_ADDR_WAIT, 4'h0, 4'h0, 1'b0);
      $display("test stop done");
      repeat (4) @(negedge sys_clk_i);
      summarize();
   end
endmodule
